// File: design/pic_ctrl_top.sv
`timescale 1ns/10ps
// Functional notes
// - response from request to service start lies within 200ns to 480ns.
// - each request is served as standard interrupt or event transfer.
// - standard interrupt suspends program and branches to the source vector.
// - an event transfer takes exactly one cycle from the cpu.
// - transfer moves byte or word, then bumps source or destination pointer.
// - transfer count decrements per transfer except in continuous mode.
// - count at zero turns the request into a standard interrupt.
// - eight independent channels with own pointers and counter.
// - every source has a control register with request, enable, level.
// - level field picks one of sixteen priority levels.
// - a running service is preempted only by strictly higher level.
// - each source has its own vector, shared with no other.
// - fast inputs detect rising, falling or both edges per input.
// - software trap with a number gives the same service as hardware.
// - vector address is four times the trap number.
// - source map of 56 sources with trap numbers 10h up to 47h.
// - hardware traps are immediate, unmaskable, flagged, and preempted only by a further hardware or software trap.
module pic_ctrl_top
    import pic_pkg::*;
(
    input wire logic mclk,
    input wire logic sys_rst,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic hreadyout,
    output logic hresp,
    output logic [31:0] hrdata,
    input wire logic [NSRC-1:0] src_event,
    input wire logic [NFAST-1:0] fast_in,
    input wire logic [NTRAP-1:0] hw_trap,
    input wire logic sw_trap,
    input wire logic [6:0] sw_trap_num,
    output logic int_req,
    output logic [23:0] int_vec,
    output logic [3:0] int_lvl,
    input wire logic int_ack,
    input wire logic int_ret,
    output logic xfer_valid,
    output pic_xfer_s xfer,
    output logic irq
);

    // ********************************************
    // bus slave
    // ********************************************
    logic wr_pend_r;
    logic [11:0] wr_addr_r;
    logic [31:0] rdata_r;
    logic bus_go;
    logic [11:0] ra;
    logic [3:0] wpage;
    logic [5:0] widx;
    logic wr_ctrl;
    logic wr_chan;
    logic [2:0] wch;
    logic [1:0] wreg;

    assign bus_go = hsel && hready && htrans[1];
    assign ra = haddr[11:0];
    assign wpage = wr_addr_r[11:8];
    assign widx = wr_addr_r[7:2];
    assign wr_ctrl = wr_pend_r && wpage == PAGE_CTRL && widx < 6'(NSRC);
    assign wr_chan = wr_pend_r && wpage == PAGE_CHAN && !wr_addr_r[7];
    assign wch = wr_addr_r[6:4];
    assign wreg = wr_addr_r[3:2];
    assign hreadyout = 1'b1; // zero wait states
    assign hresp = 1'b0;
    assign hrdata = rdata_r;

    // ********************************************
    // state
    // ********************************************
    pic_ctrl_s ctrl_r [NSRC];
    logic [NTRAP-1:0] trap_flag_r;
    logic [NTRAP-1:0] trap_pend_r;
    logic [15:0] fast_cfg_r;
    logic [2:0] stat_r;
    logic [2:0] mask_r;
    logic sw_pend_r;
    logic [6:0] sw_num_r;
    pic_state_e state_r;
    pic_state_e state_nxt;
    pic_kind_e kind_r;
    logic [5:0] win_idx_r;
    logic [3:0] win_lvl_r;
    logic win_std_r;
    logic [2:0] win_ch_r;
    logic [5:0] lat_cnt_r;
    logic [3:0] cur_lvl_r;
    logic trap_act_r;
    logic [4:0] stk_r [16];
    logic [4:0] sp_r;
    logic [23:0] vec_r;
    logic [3:0] lvl_r;
    pic_xfer_s xfer_r;

    // ********************************************
    // fast inputs and channels
    // ********************************************
    logic [NFAST-1:0] fast_pulse;
    logic [NSRC-1:0] src_set;
    pic_xfer_s ch_xfer [NCHAN];
    logic [7:0] ch_cnt [NCHAN];
    pic_chcfg_s ch_cfg [NCHAN];
    logic [NCHAN-1:0] ch_zero;

    genvar g;
    generate
        for (g = 0; g < NFAST; g++)
        begin : g_fast
            pic_edge_det u_edge (
                .mclk(mclk),
                .sys_rst(sys_rst),
                .sig(fast_in[g]),
                .mode(fast_cfg_r[2*g +: 2]),
                .pulse(fast_pulse[g])
            );
        end
        for (g = 0; g < NCHAN; g++)
        begin : g_chan
            pic_event_chan u_chan (
                .mclk(mclk),
                .sys_rst(sys_rst),
                .wr_en({4{wr_chan && wch == 3'(g)}} &
                    (4'h1 << wreg)),
                .wr_data(hwdata),
                .fire(state_r == S_XFER && win_ch_r == 3'(g)),
                .xfer(ch_xfer[g]),
                .count(ch_cnt[g]),
                .cfg(ch_cfg[g]),
                .count_zero(ch_zero[g])
            );
        end
    endgenerate

    // fast inputs feed sources 8 to 15
    assign src_set = src_event |
        (NSRC'(fast_pulse) << FAST_SRC_BASE);

    // ********************************************
    // arbitration
    // ********************************************
    logic arb_found;
    logic [5:0] arb_idx;
    logic [3:0] arb_lvl;

    // highest level wins, strict compare keeps lowest index on ties
    always_comb
    begin
        arb_found = 1'b0;
        arb_idx = 6'h00;
        arb_lvl = 4'h0;
        for (int i = 0; i < NSRC; i++)
        begin
            if (ctrl_r[i].req && ctrl_r[i].en && !trap_act_r &&
                ctrl_r[i].lvl > cur_lvl_r &&
                (!arb_found || ctrl_r[i].lvl > arb_lvl))
            begin
                arb_found = 1'b1;
                arb_idx = 6'(i);
                arb_lvl = ctrl_r[i].lvl;
            end
        end
    end

    logic trap_any;
    logic [1:0] trap_sel;
    logic arb_std;
    logic accept;
    logic taking;

    assign trap_any = |trap_pend_r;
    assign trap_sel = trap_pend_r[0] ? 2'd0 : trap_pend_r[1] ? 2'd1 :
        trap_pend_r[2] ? 2'd2 : 2'd3;
    // chosen service: transfer if xfer is set and count is not spent, else standard
    assign arb_std = !ctrl_r[arb_idx].xfer ||
        ch_zero[ctrl_r[arb_idx].chan];
    assign accept = state_r == S_PRESENT && int_ack;
    assign taking = state_r == S_IDLE && !trap_any && !sw_pend_r &&
        arb_found;

    // ********************************************
    // service sequencer
    // ********************************************
    always_comb
    begin
        state_nxt = state_r;
        case (state_r)
            S_IDLE:
            begin
                if (trap_any || sw_pend_r)
                    state_nxt = S_PRESENT;
                else if (arb_found)
                    state_nxt = S_WAIT;
            end
            S_WAIT:
            begin
                if (trap_any)
                    state_nxt = S_IDLE;
                else if (lat_cnt_r == LAT_WAIT_LAST)
                    state_nxt = win_std_r ? S_PRESENT : S_XFER;
            end
            S_PRESENT:
            begin
                if (int_ack)
                    state_nxt = S_IDLE;
            end
            S_XFER: state_nxt = S_IDLE;
            default: state_nxt = S_IDLE;
        endcase
    end

    // sequencer registers and latched winner
    always_ff @(posedge mclk)
    begin
        if (sys_rst)
        begin
            state_r <= S_IDLE;
            kind_r <= K_STD;
            win_idx_r <= 6'h00;
            win_lvl_r <= 4'h0;
            win_std_r <= 1'b0;
            win_ch_r <= 3'h0;
            lat_cnt_r <= 6'h00;
            vec_r <= 24'h000000;
            lvl_r <= 4'h0;
            xfer_r <= '0;
        end
        else
        begin
            state_r <= state_nxt;
            lat_cnt_r <= (state_r == S_WAIT) ? lat_cnt_r + 6'h01 : 6'h00;
            if (state_r == S_IDLE && trap_any)
            begin
                kind_r <= K_HWTRAP;
                vec_r <= {15'h0000, TRAP_NUM[trap_sel], 2'b00};
                lvl_r <= 4'hF;
            end
            else if (state_r == S_IDLE && sw_pend_r)
            begin
                kind_r <= K_SWTRAP;
                vec_r <= {15'h0000, sw_num_r, 2'b00};
                lvl_r <= cur_lvl_r;
            end
            else if (taking)
            begin
                kind_r <= K_STD;
                win_idx_r <= arb_idx;
                win_lvl_r <= arb_lvl;
                win_std_r <= arb_std;
                win_ch_r <= ctrl_r[arb_idx].chan;
                // own vector per source, trap number base plus index
                vec_r <= {15'h0000, 7'(SRC_TRAP_BASE + 7'(arb_idx)),
                    2'b00};
                lvl_r <= arb_lvl;
            end
            if (state_r == S_WAIT && state_nxt == S_XFER)
                xfer_r <= ch_xfer[win_ch_r];
        end
    end

    assign int_req = state_r == S_PRESENT;
    assign int_vec = vec_r;
    assign int_lvl = lvl_r;
    assign xfer_valid = state_r == S_XFER;
    assign xfer = xfer_r;

    // ********************************************
    // level stack for nested services
    // ********************************************
    always_ff @(posedge mclk)
    begin
        if (sys_rst)
        begin
            cur_lvl_r <= 4'h0;
            trap_act_r <= 1'b0;
            sp_r <= 5'h00;
        end
        else if (accept)
        begin
            if (sp_r != STK_DEPTH)
                sp_r <= sp_r + 5'h01;
            if (kind_r == K_HWTRAP)
                trap_act_r <= 1'b1;
            else if (kind_r == K_STD)
                cur_lvl_r <= win_lvl_r;
        end
        else if (int_ret && sp_r != 5'h00)
        begin
            sp_r <= sp_r - 5'h01;
            {trap_act_r, cur_lvl_r} <= stk_r[sp_r[3:0] - 4'h1];
        end
    end

    // saved context, no reset needed
    always_ff @(posedge mclk)
    begin
        if (accept && sp_r != STK_DEPTH)
            stk_r[sp_r[3:0]] <= {trap_act_r, cur_lvl_r};
    end

    // ********************************************
    // source control registers
    // ********************************************
    logic [NSRC-1:0] src_clr;
    logic [NSRC-1:0] src_wr;

    // flag cleared when its service is taken up
    always_comb
    begin
        for (int i = 0; i < NSRC; i++)
        begin
            src_clr[i] = win_idx_r == 6'(i) && kind_r == K_STD &&
                (accept || state_r == S_XFER);
            src_wr[i] = wr_ctrl && widx == 6'(i);
        end
    end

    // write takes the field values, hardware set wins over clear
    always_ff @(posedge mclk)
    begin
        for (int i = 0; i < NSRC; i++)
        begin
            if (sys_rst)
                ctrl_r[i] <= CTRL_RST;
            else
            begin
                if (src_wr[i])
                    ctrl_r[i] <= '{chan: hwdata[CTL_CH_LSB +: 3],
                        xfer: hwdata[CTL_XFER_BIT],
                        req: hwdata[CTL_REQ_BIT] | src_set[i],
                        en: hwdata[CTL_EN_BIT],
                        lvl: hwdata[CTL_LVL_LSB +: 4]};
                else
                    ctrl_r[i].req <= src_set[i] |
                        (ctrl_r[i].req & ~src_clr[i]);
            end
        end
    end

    // ********************************************
    // traps, status and interrupt line
    // ********************************************
    logic [2:0] stat_set;
    logic trap_taken;

    assign trap_taken = accept && kind_r == K_HWTRAP;
    assign stat_set = {accept && kind_r == K_SWTRAP,
        |hw_trap, taking && arb_std && ctrl_r[arb_idx].xfer};

    always_ff @(posedge mclk)
    begin
        if (sys_rst)
        begin
            trap_flag_r <= '0;
            trap_pend_r <= '0;
            sw_pend_r <= 1'b0;
            sw_num_r <= 7'h00;
            fast_cfg_r <= 16'h0000;
            stat_r <= 3'h0;
            mask_r <= 3'h0;
            wr_pend_r <= 1'b0;
            wr_addr_r <= 12'h000;
        end
        else
        begin
            wr_pend_r <= bus_go && hwrite;
            wr_addr_r <= ra;
            // unmaskable, pending until taken
            trap_pend_r <= hw_trap | (trap_pend_r &
                ~(trap_taken ? NTRAP'(1) << trap_sel : '0));
            trap_flag_r <= hw_trap | (trap_flag_r & ~((wr_pend_r &&
                wr_addr_r == OFS_TRAPFLAG) ? hwdata[NTRAP-1:0] : '0));
            if (sw_trap)
            begin
                sw_pend_r <= 1'b1;
                sw_num_r <= sw_trap_num;
            end
            else if (accept && kind_r == K_SWTRAP)
                sw_pend_r <= 1'b0;
            if (wr_pend_r && wr_addr_r == OFS_FASTCFG)
                fast_cfg_r <= hwdata[15:0];
            if (wr_pend_r && wr_addr_r == OFS_MASK)
                mask_r <= hwdata[2:0];
            stat_r <= stat_set | (stat_r & ~((wr_pend_r &&
                wr_addr_r == OFS_STATUS) ? hwdata[2:0] : 3'h0));
        end
    end

    assign irq = |(stat_r & mask_r);

    // ********************************************
    // read data
    // ********************************************
    logic [31:0] rd_ctrl;
    logic [31:0] rd_chan;
    logic [31:0] rd_val;
    logic [5:0] ridx;
    logic [2:0] rch;

    assign ridx = ra[7:2];
    assign rch = ra[6:4];
    assign rd_ctrl = (ridx < 6'(NSRC)) ? {20'h00000, ctrl_r[ridx].chan,
        ctrl_r[ridx].xfer, ctrl_r[ridx].req, ctrl_r[ridx].en, 2'b00,
        ctrl_r[ridx].lvl} : 32'h00000000;
    assign rd_chan = ra[3:2] == CH_SRC ? {8'h00, ch_xfer[rch].src} :
        ra[3:2] == CH_DST ? {8'h00, ch_xfer[rch].dst} :
        ra[3:2] == CH_CNT ? {24'h000000, ch_cnt[rch]} :
        {29'h00000000, ch_cfg[rch]};
    assign rd_val = ra[11:8] == PAGE_CTRL ? rd_ctrl :
        ra[11:8] == PAGE_CHAN && !ra[7] ? rd_chan :
        ra == OFS_TRAPFLAG ? {28'h0000000, trap_flag_r} :
        ra == OFS_FASTCFG ? {16'h0000, fast_cfg_r} :
        ra == OFS_STATUS ? {29'h00000000, stat_r} :
        ra == OFS_MASK ? {29'h00000000, mask_r} :
        ra == OFS_CURLVL ? {27'h0000000, trap_act_r, cur_lvl_r} :
        32'h00000000;

    // read word captured in address phase
    always_ff @(posedge mclk)
    begin
        if (sys_rst)
            rdata_r <= 32'h00000000;
        else if (bus_go && !hwrite)
            rdata_r <= rd_val;
    end

    // ********************************************
    // checks
    // ********************************************
    default clocking cb @(posedge mclk); endclocking
    default disable iff (sys_rst);

    lat_window_a: assert property (state_r == S_WAIT &&
        (state_nxt == S_PRESENT || state_nxt == S_XFER) |->
        lat_cnt_r >= 6'(LAT_MIN_CYC - 1) && lat_cnt_r < 6'(LAT_MAX_CYC))
        else $error("service started outside latency window");
    xfer_single_a: assert property (xfer_valid |=> !xfer_valid)
        else $error("transfer held longer than one cycle");
    cnt_step_a: assert property (xfer_valid &&
        !ch_cfg[win_ch_r].cont |=> ch_cnt[win_ch_r] ==
        $past(ch_cnt[win_ch_r]) - 8'h01)
        else $error("count did not decrement");
    cont_hold_a: assert property (xfer_valid &&
        ch_cfg[win_ch_r].cont |=> $stable(ch_cnt[win_ch_r]))
        else $error("continuous count changed");
    zero_std_a: assert property (taking && ch_zero[ctrl_r[arb_idx].chan]
        |=> win_std_r ##[1:60] int_req)
        else $error("spent channel did not interrupt");
    vec_map_a: assert property (int_req && kind_r == K_STD |->
        int_vec == {15'h0000, 7'(SRC_TRAP_BASE + 7'(win_idx_r)), 2'b00})
        else $error("wrong vector for source");
    preempt_a: assert property (accept && kind_r == K_STD |->
        int_lvl > cur_lvl_r) else $error("preempted without higher level");
    flag_clr_a: assert property (accept && kind_r == K_STD |=>
        !ctrl_r[win_idx_r].req || $past(src_set[win_idx_r]))
        else $error("request flag not cleared");
    trap_fast_a: assert property (state_r == S_IDLE && trap_any |=>
        int_req && kind_r == K_HWTRAP)
        else $error("trap not served at once");

    std_c: cover property (accept && kind_r == K_STD);
    xfer_c: cover property (xfer_valid);
    trap_c: cover property (trap_taken);
    nest_c: cover property (sp_r >= 5'h02);

endmodule

// File: design/pic_pkg.sv
package pic_pkg;

    // ********************************************
    // sizes and timing
    // ********************************************
    localparam int NSRC = 56;
    localparam int NCHAN = 8;
    localparam int NTRAP = 4;
    localparam int NFAST = 8;
    localparam logic [6:0] SRC_TRAP_BASE = 7'h10;
    localparam logic [5:0] FAST_SRC_BASE = 6'h08;
    localparam int CLK_PERIOD_NS = 10;
    localparam int LAT_MIN_NS = 200;
    localparam int LAT_MAX_NS = 480;
    localparam int LAT_MIN_CYC =
        (LAT_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int LAT_MAX_CYC = LAT_MAX_NS / CLK_PERIOD_NS;
    localparam logic [5:0] LAT_WAIT_LAST = 6'(LAT_MIN_CYC - 1);
    localparam logic [4:0] STK_DEPTH = 5'h10;

    // ********************************************
    // register map
    // ********************************************
    localparam logic [3:0] PAGE_CTRL = 4'h0;
    localparam logic [3:0] PAGE_CHAN = 4'h1;
    localparam logic [11:0] OFS_TRAPFLAG = 12'h200;
    localparam logic [11:0] OFS_FASTCFG = 12'h204;
    localparam logic [11:0] OFS_STATUS = 12'h208;
    localparam logic [11:0] OFS_MASK = 12'h20C;
    localparam logic [11:0] OFS_CURLVL = 12'h210;
    localparam logic [1:0] CH_SRC = 2'h0;
    localparam logic [1:0] CH_DST = 2'h1;
    localparam logic [1:0] CH_CNT = 2'h2;
    localparam logic [1:0] CH_CFG = 2'h3;

    // control register fields
    localparam int CTL_LVL_LSB = 0;
    localparam int CTL_EN_BIT = 6;
    localparam int CTL_REQ_BIT = 7;
    localparam int CTL_XFER_BIT = 8;
    localparam int CTL_CH_LSB = 9;
    // channel config fields
    localparam int CFG_WORD_BIT = 0;
    localparam int CFG_INCDST_BIT = 1;
    localparam int CFG_CONT_BIT = 2;
    // status bits
    localparam int ST_TERM = 0;
    localparam int ST_HWTRAP = 1;
    localparam int ST_SWTRAP = 2;

    // hardware trap numbers, index 0 most urgent
    localparam logic [6:0] TRAP_NUM [NTRAP] =
        '{7'h02, 7'h04, 7'h06, 7'h0A};

    // ********************************************
    // types
    // ********************************************
    typedef struct packed {
        logic [2:0] chan;
        logic xfer;
        logic req;
        logic en;
        logic [3:0] lvl;
    } pic_ctrl_s;

    typedef struct packed {
        logic cont;
        logic inc_dst;
        logic word;
    } pic_chcfg_s;

    typedef struct packed {
        logic [23:0] src;
        logic [23:0] dst;
        logic word;
    } pic_xfer_s;

    typedef enum logic [1:0] {
        S_IDLE = 2'b00,
        S_WAIT = 2'b01,
        S_PRESENT = 2'b10,
        S_XFER = 2'b11
    } pic_state_e;

    typedef enum logic [1:0] {
        K_STD = 2'b00,
        K_HWTRAP = 2'b01,
        K_SWTRAP = 2'b10
    } pic_kind_e;

    localparam pic_ctrl_s CTRL_RST = '0;
    localparam pic_chcfg_s CHCFG_RST = '0;

endpackage

// File: design/pic_edge_det.sv
`timescale 1ns/10ps
module pic_edge_det
    import pic_pkg::*;
(
    input wire logic mclk,
    input wire logic sys_rst,
    input wire logic sig,
    input wire logic [1:0] mode,
    output logic pulse
);

    logic prev_r;
    logic rise;
    logic fall;

    // previous level of the input
    always_ff @(posedge mclk)
    begin
        if (sys_rst)
            prev_r <= 1'b0;
        else
            prev_r <= sig;
    end

    // mode bit 0 picks rising, bit 1 falling, both for either edge
    assign rise = sig & ~prev_r;
    assign fall = ~sig & prev_r;
    assign pulse = (mode[0] & rise) | (mode[1] & fall);

endmodule

// File: design/pic_event_chan.sv
`timescale 1ns/10ps
module pic_event_chan
    import pic_pkg::*;
(
    input wire logic mclk,
    input wire logic sys_rst,
    input wire logic [3:0] wr_en,
    input wire logic [31:0] wr_data,
    input wire logic fire,
    output pic_xfer_s xfer,
    output logic [7:0] count,
    output pic_chcfg_s cfg,
    output logic count_zero
);

    logic [23:0] src_r;
    logic [23:0] dst_r;
    logic [7:0] cnt_r;
    pic_chcfg_s cfg_r;
    logic [23:0] src_nxt;
    logic [23:0] dst_nxt;
    logic [7:0] cnt_nxt;
    pic_chcfg_s cfg_nxt;
    logic [23:0] step;

    // one pointer moves per transfer, by a byte or a word
    assign step = cfg_r.word ? 24'h000002 : 24'h000001;
    assign src_nxt = wr_en[0] ? wr_data[23:0] :
        (fire && !cfg_r.inc_dst) ? src_r + step : src_r;
    assign dst_nxt = wr_en[1] ? wr_data[23:0] :
        (fire && cfg_r.inc_dst) ? dst_r + step : dst_r;
    // count holds in continuous mode
    assign cnt_nxt = wr_en[2] ? wr_data[7:0] :
        (fire && !cfg_r.cont && cnt_r != 8'h00) ?
        cnt_r - 8'h01 : cnt_r;
    assign cfg_nxt = wr_en[3] ? pic_chcfg_s'(wr_data[2:0]) : cfg_r;

    // channel state
    always_ff @(posedge mclk)
    begin
        if (sys_rst)
        begin
            src_r <= 24'h000000;
            dst_r <= 24'h000000;
            cnt_r <= 8'h00;
            cfg_r <= CHCFG_RST;
        end
        else
        begin
            src_r <= src_nxt;
            dst_r <= dst_nxt;
            cnt_r <= cnt_nxt;
            cfg_r <= cfg_nxt;
        end
    end

    assign xfer = '{src: src_r, dst: dst_r, word: cfg_r.word};
    assign count = cnt_r;
    assign cfg = cfg_r;
    assign count_zero = (cnt_r == 8'h00) && !cfg_r.cont;

endmodule

// File: testbench/pic_cpu_model.sv
`timescale 1ns/10ps
module pic_cpu_model
    import pic_pkg::*;
#(
    parameter int ACK_DLY = 3,
    parameter int SVC_LEN = 6
)
(
    input wire logic mclk,
    input wire logic sys_rst,
    input wire logic int_req,
    output logic int_ack = 1'b0,
    output logic int_ret = 1'b0
);
    int wait_n = 0;
    int svc_n = 0;
    // accept a request after a delay, then end the service later
    always @(posedge mclk)
    begin
        wait_n <= (int_req && !int_ack && !sys_rst) ? wait_n + 1 : 0;
        svc_n <= (svc_n > 0 && !sys_rst) ? svc_n - 1 : 0;
        int_ret <= (svc_n == 1) && !sys_rst;
        int_ack <= int_req && !int_ack && wait_n == ACK_DLY;
        if (int_req && !int_ack && wait_n == ACK_DLY)
            svc_n <= SVC_LEN;
    end
endmodule

// File: testbench/prioritized_interrupt_and_event_transfer_bench.sv
`timescale 1ns/10ps
module prioritized_interrupt_and_event_transfer_bench;
    import pic_pkg::*;
    logic mclk = 1'b0, sys_rst = 1'b1, hsel = 1'b0, hwrite = 1'b0;
    logic sw_trap = 1'b0;
    logic [1:0] htrans = 2'h0;
    logic [2:0] hsize = 3'h2;
    logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, rd;
    logic [55:0] src_event = 56'h0;
    logic [7:0] fast_in = 8'h0;
    logic [3:0] hw_trap = 4'h0, int_lvl;
    logic [6:0] sw_trap_num = 7'h0;
    logic hreadyout, hresp, int_req, int_ack, int_ret, xfer_valid, irq;
    logic [23:0] int_vec;
    pic_xfer_s xfer;
    int miscompares = 0, n_tests = 0, n;
    pic_ctrl_top i_dut (.mclk, .sys_rst, .hsel, .haddr, .htrans, .hwrite,
        .hsize, .hwdata, .hready(hreadyout), .hreadyout, .hresp, .hrdata,
        .src_event, .fast_in, .hw_trap, .sw_trap, .sw_trap_num, .int_req,
        .int_vec, .int_lvl, .int_ack, .int_ret, .xfer_valid, .xfer, .irq);
    pic_cpu_model i_cpu (.mclk, .sys_rst, .int_req, .int_ack, .int_ret);
    // ****************
    // bus and checks
    // ****************
    task chk(input logic [31:0] got, input logic [31:0] exp);
        n_tests++;
        if (got !== exp)
        begin
            miscompares++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    // one AHB single transfer, read data left in rd
    task bus(input logic w, input logic [31:0] a, input logic [31:0] d);
        hsel <= 1'b1;
        htrans <= 2'h2;
        haddr <= a;
        hwrite <= w;
        do @(posedge mclk); while (hreadyout !== 1'b1);
        htrans <= 2'h0;
        hwdata <= d;
        do @(posedge mclk); while (hreadyout !== 1'b1);
        rd = hrdata;
    endtask
    // wait for int_req (x=0) or xfer_valid (x=1), bounded
    task wt(input logic x);
        n = 0;
        while ((x ? xfer_valid : int_req) !== 1'b1 && n < 100)
        begin
            @(posedge mclk);
            n++;
        end
        if (n == 100)
        begin
            miscompares++;
            $display("Error at %0t: wait timed out", $time);
        end
    endtask
    task ev(input logic [55:0] m);
        src_event <= m;
        @(posedge mclk);
        src_event <= 56'h0;
    endtask
    task complete_run;
        $display("checks %0d, mismatches %0d", n_tests, miscompares);
        if (miscompares == 0 && n_tests > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask
    // ****************
    // clock and tests
    // ****************
    initial forever #5 mclk = ~mclk;
    initial
    begin
        repeat (5000) @(posedge mclk);
        miscompares++;
        $display("Error at %0t: watchdog expired", $time);
        complete_run;
    end
    initial
    begin
        repeat (4) @(posedge mclk);
        sys_rst <= 1'b0;
        @(posedge mclk);
        bus(1'b0, 32'h0, 32'h0);
        chk(rd, 32'h0);
        bus(1'b1, 32'hC, 32'h45);
        ev(56'h8);
        wt(1'b0);
        chk(n >= LAT_MIN_CYC && n <= LAT_MAX_CYC, 32'h1);
        chk(int_vec, 32'h4C);
        chk(int_lvl, 32'h5);
        repeat (14) @(posedge mclk);
        bus(1'b0, 32'hC, 32'h0);
        chk(rd, 32'h45);
        bus(1'b1, 32'h4, 32'h42);
        bus(1'b1, 32'h8, 32'h47);
        ev(56'h6);
        wt(1'b0);
        chk(int_vec, 32'h48);
        repeat (6) @(posedge mclk);
        wt(1'b0);
        chk(int_vec, 32'h44);
        repeat (14) @(posedge mclk);
        sw_trap_num <= 7'h25;
        sw_trap <= 1'b1;
        @(posedge mclk);
        sw_trap <= 1'b0;
        wt(1'b0);
        chk(int_vec, 32'h94);
        repeat (14) @(posedge mclk);
        bus(1'b1, 32'h100, 32'h100);
        bus(1'b1, 32'h104, 32'h200);
        bus(1'b1, 32'h108, 32'h2);
        bus(1'b1, 32'h10C, 32'h0);
        bus(1'b1, 32'h20C, 32'h1);
        bus(1'b1, 32'h10, 32'h143);
        for (int k = 0; k < 2; k++)
        begin
            ev(56'h10);
            wt(1'b1);
            chk(xfer.src, 32'h100 + k);
            chk(xfer.dst, 32'h200);
            @(posedge mclk);
            chk(xfer_valid, 32'h0);
        end
        bus(1'b0, 32'h108, 32'h0);
        chk(rd, 32'h0);
        ev(56'h10);
        wt(1'b0);
        chk(int_vec, 32'h50);
        repeat (2) @(posedge mclk);
        chk(irq, 32'h1);
        bus(1'b1, 32'h208, 32'h1);
        @(posedge mclk);
        chk(irq, 32'h0);
        repeat (14) @(posedge mclk);
        // fast input 0 set to falling edge only, feeds source 8
        bus(1'b1, 32'h204, 32'h2);
        bus(1'b1, 32'h20, 32'h41);
        fast_in <= 8'h1;
        @(posedge mclk);
        bus(1'b0, 32'h20, 32'h0);
        chk(rd, 32'h41);
        fast_in <= 8'h0;
        wt(1'b0);
        chk(int_vec, 32'h60);
        repeat (14) @(posedge mclk);
        // hardware trap on input 1
        hw_trap <= 4'h2;
        @(posedge mclk);
        hw_trap <= 4'h0;
        wt(1'b0);
        chk(int_vec, 32'h10);
        chk(int_lvl, 32'hF);
        bus(1'b0, 32'h200, 32'h0);
        chk(rd, 32'h2);
        repeat (14) @(posedge mclk);
        complete_run;
    end
endmodule
